// ---- rtl/tfic_regs.vh ----
/*
  constants of the time-flag and identification command block: command codes,
  packet lengths, status bit position, reply lengths and reset values.
  assumes it is included by bare name from the block's design files.
*/
// Function
// - code 0x40 sets local-time flag, default on
// - enabled flag adds local offset to time
// - code 0x41 returns flag in bit 3
// - code 0x42 flag, enabled stores year yearly
// - code 0x4f returns part and revision characters
// - code 0xf4 returns 16-bit assembly number
// - code 0xf5 returns 16-bit fabrication number
// - code 0xf6 returns model string, byte 5 variant
// - code 0xf7 returns 32-bit serial number
// - identification values never change by packets
`ifndef TFIC_REGS_VH
`define TFIC_REGS_VH

// command codes
`define TFIC_CMD_REQ_DATA   8'h19
`define TFIC_CMD_SET_LOCAL  8'h40
`define TFIC_CMD_REQ_LOCAL  8'h41
`define TFIC_CMD_SET_YEAR   8'h42
`define TFIC_CMD_FW_PART    8'h4F
`define TFIC_CMD_ASSEMBLY   8'hF4
`define TFIC_CMD_FAB        8'hF5
`define TFIC_CMD_MODEL      8'hF6
`define TFIC_CMD_SERIAL     8'hF7

// flag byte values
`define TFIC_FLAG_OFF       8'h00
`define TFIC_FLAG_ON        8'h01

// flag reset values
`define TFIC_LOCAL_RST      1'b1
`define TFIC_YEAR_RST       1'b1

// status byte: position of the local-time observe flag
`define TFIC_STAT_LOCAL_BIT 3

// packet length of a flag-setting command, in bytes
`define TFIC_FLAG_PKT_LEN   2'h2

// reply lengths in bytes, code byte included
`define TFIC_LEN_STATUS     4'h2
`define TFIC_LEN_FW         4'hC
`define TFIC_LEN_ASSY       4'h3
`define TFIC_LEN_FAB        4'h3
`define TFIC_LEN_MODEL      4'h9
`define TFIC_LEN_SERIAL     4'h5

// reply buffer geometry
`define TFIC_BUF_DEPTH      16
`define TFIC_BUF_AW         4

`endif

// ---- rtl/tfic_reply_mem.v ----
/*
  small reply buffer: one write port, one read port with registered data.
  assumes a single clock; write and read addresses come from the same domain.
*/
`timescale 1ns/1ps
module tfic_reply_mem #(
  parameter AW    = 4,                // address width
  parameter DEPTH = 16,               // number of bytes held
  parameter DW    = 8                 // data width
) (
  input  wire          clk_sys,       // system clock
  input  wire          wr_en,         // write strobe
  input  wire [AW-1:0] wr_addr,       // write address
  input  wire [DW-1:0] wr_data,       // write data
  input  wire [AW-1:0] rd_addr,       // read address
  output reg  [DW-1:0] rd_data        // read data, one cycle after address
);

  reg [DW-1:0] mem [0:DEPTH-1];       // byte storage

  // write port
  always @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read port
  always @(posedge clk_sys)
  begin
    rd_data <= mem[rd_addr];
  end

endmodule

// ---- rtl/tfic_time_adj.v ----
/*
  local-time adjuster: adds the programmed offset to the reported time while
  local time is observed, else passes the time through; output is registered.
  assumes time and offset are in the same unit and on the system clock.
*/
`timescale 1ns/1ps
module tfic_time_adj #(
  parameter TW = 32                   // time word width
) (
  input  wire          clk_sys,       // system clock
  input  wire          sys_rst,       // synchronous reset, active high
  input  wire          local_en,      // local-time observe flag
  input  wire [TW-1:0] time_in,       // reference time
  input  wire [TW-1:0] offset_in,     // local offset, two's complement
  output reg  [TW-1:0] time_out       // reported time
);

  wire [TW-1:0] sum_time;             // time with offset applied

  // wraps modulo 2^TW, the offset is signed
  assign sum_time = time_in + offset_in;

  // choose adjusted or plain time
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      time_out <= {TW{1'b0}};
    end
    else if (local_en)
    begin
      time_out <= sum_time;
    end
    else
    begin
      time_out <= time_in;
    end
  end

endmodule

// ---- rtl/tfic_top.v ----
/*
  command interpreter slice for the local-time and year flags and the
  identification queries of the time_frequency_processor. host packets
  arrive a byte at a time with valid/ready and a last marker; query replies
  are built into a buffer and streamed out when the data-request code comes.
  assumes the packet stream and the time and year inputs share clk_sys; only
  the variant strap pin is asynchronous and is synchronised here.
*/
`timescale 1ns/1ps
`include "tfic_regs.vh"
module tfic_top #(
  parameter [47:0] PART_ID  = 48'h58_58_30_30_30_30, // arbitrary value
  parameter [39:0] FW_REV   = 40'h30_30_30_30_31,    // arbitrary value
  parameter [15:0] ASSY_NUM = 16'h0001,              // arbitrary value
  parameter [15:0] FAB_NUM  = 16'h0002,              // arbitrary value
  parameter [63:0] MODEL    = 64'h4D_44_4C_30_30_50_43_49, // arbitrary value
  parameter [7:0]  CH_TCODE = 8'h35,                 // arbitrary value
  parameter [7:0]  CH_GPS   = 8'h37,                 // arbitrary value
  parameter [31:0] SERIAL   = 32'h0000_0001,         // arbitrary value
  parameter        TW       = 32                     // time word width
) (
  input  wire          clk_sys,       // system clock, 50 MHz
  input  wire          sys_rst,       // synchronous reset, active high
  input  wire          cmd_valid,     // packet byte offered
  input  wire [7:0]    cmd_data,      // packet byte
  input  wire          cmd_last,      // last byte of the packet
  output wire          cmd_ready,     // packet byte accepted
  output wire          rsp_valid,     // reply byte offered
  output wire [7:0]    rsp_data,      // reply byte, from a register
  output wire          rsp_last,      // last byte of the reply
  input  wire          rsp_ready,     // reply byte taken by host
  input  wire          variant_pin,   // strap: high for the satellite variant
  input  wire [TW-1:0] time_in,       // reference time
  input  wire [TW-1:0] local_offset,  // programmed local offset
  output wire [TW-1:0] time_out,      // reported time
  output reg           local_en,      // local-time observe flag
  output reg           year_auto_en,  // year auto increment flag
  input  wire          year_start,    // pulse at the start of a year
  input  wire [15:0]   year_value,    // current year
  output reg           nv_wr_req,     // year store request, held until ack
  output reg  [15:0]   nv_year,       // year value to store
  input  wire          nv_wr_ack      // store accepted
);

  // fsm states
  localparam [1:0] S_RX    = 2'h0;    // receiving packets
  localparam [1:0] S_BUILD = 2'h1;    // writing a reply into the buffer
  localparam [1:0] S_LOAD  = 2'h2;    // buffer read latency
  localparam [1:0] S_SEND  = 2'h3;    // offering a reply byte

  reg  [1:0]  state;                  // current state
  reg  [1:0]  next_state;             // next state
  reg  [1:0]  rx_cnt;                 // bytes so far in packet, saturating
  reg  [7:0]  rx_code;                // byte 0 of the packet
  reg  [7:0]  rx_flag;                // byte 1 of the packet
  reg  [7:0]  rpl_code;               // code of the buffered reply
  reg  [3:0]  rpl_len;                // length of the buffered reply
  reg         rpl_ok;                 // a reply is buffered
  reg  [3:0]  bld_idx;                // byte being built
  reg  [3:0]  rd_idx;                 // byte being read out
  reg         var_meta;               // strap synchroniser, first stage
  reg         var_sync;               // strap synchroniser, second stage
  reg         var_cap;                // captured variant
  reg         var_done;               // variant captured since reset
  wire        rx_take;                // packet byte accepted this cycle
  wire        pkt_end;                // last byte accepted this cycle
  wire [7:0]  pkt_code;               // code of the ending packet
  wire [7:0]  pkt_flag;               // flag byte of the ending packet
  wire [1:0]  pkt_len;                // length of the ending packet
  wire        flag_ok;                // flag packet is well formed
  wire        is_query;               // ending packet is a query
  wire [7:0]  bld_byte;               // reply byte for the buffer
  wire        bld_wr;                 // buffer write strobe
  wire [3:0]  rd_addr;                // buffer read address

  // length of the reply to a query code, zero when not a query
  function [3:0] reply_len;
    input [7:0] code;                 // command code
    begin
      case (code)
        `TFIC_CMD_REQ_LOCAL: reply_len = `TFIC_LEN_STATUS;
        `TFIC_CMD_FW_PART:   reply_len = `TFIC_LEN_FW;
        `TFIC_CMD_ASSEMBLY:  reply_len = `TFIC_LEN_ASSY;
        `TFIC_CMD_FAB:       reply_len = `TFIC_LEN_FAB;
        `TFIC_CMD_MODEL:     reply_len = `TFIC_LEN_MODEL;
        `TFIC_CMD_SERIAL:    reply_len = `TFIC_LEN_SERIAL;
        default:             reply_len = 4'h0;
      endcase
    end
  endfunction

  // one byte of a reply; the frame holds byte 0 in its top eight bits
  function [7:0] reply_byte;
    input [7:0] code;                 // command code
    input [3:0] idx;                  // byte index within the reply
    input       flag;                 // local-time observe flag
    input       gps;                  // satellite variant
    reg   [95:0] frame;               // whole reply, left aligned
    reg   [95:0] shifted;             // frame moved to the wanted byte
    begin
      case (code)
        `TFIC_CMD_REQ_LOCAL:
          frame = {code, 4'h0, flag, 3'h0, 80'h0};
        `TFIC_CMD_FW_PART:
          frame = {code, PART_ID, FW_REV};
        `TFIC_CMD_ASSEMBLY:
          frame = {code, ASSY_NUM, 72'h0};
        `TFIC_CMD_FAB:
          frame = {code, FAB_NUM, 72'h0};
        `TFIC_CMD_MODEL:
          frame = {code, MODEL[63:32], (gps ? CH_GPS : CH_TCODE), MODEL[23:0], 24'h0};
        `TFIC_CMD_SERIAL:
          frame = {code, SERIAL, 56'h0};
        default:
          frame = 96'h0;
      endcase
      shifted    = frame << {idx, 3'h0};
      reply_byte = shifted[95:88];
    end
  endfunction

  // packet bytes are accepted only while idle in receive
  assign cmd_ready = (state == S_RX);
  assign rx_take   = cmd_valid & cmd_ready;
  assign pkt_end   = rx_take & cmd_last;

  // the ending byte may itself be byte 0 or byte 1
  assign pkt_code = (rx_cnt == 2'h0) ? cmd_data : rx_code;
  assign pkt_flag = (rx_cnt == 2'h1) ? cmd_data : rx_flag;
  assign pkt_len  = (rx_cnt == 2'h3) ? 2'h3 : (rx_cnt + 2'h1);

  // a flag packet is exactly two bytes carrying 0 or 1
  assign flag_ok  = (pkt_len == `TFIC_FLAG_PKT_LEN) &&
                    ((pkt_flag == `TFIC_FLAG_OFF) || (pkt_flag == `TFIC_FLAG_ON));
  assign is_query = (reply_len(pkt_code) != 4'h0);

  // byte counting and capture of the packet header bytes
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rx_cnt  <= 2'h0;
      rx_code <= 8'h00;
      rx_flag <= 8'h00;
    end
    else if (rx_take)
    begin
      if (rx_cnt == 2'h0)
        rx_code <= cmd_data;          // code byte
      if (rx_cnt == 2'h1)
        rx_flag <= cmd_data;          // flag byte
      if (cmd_last)
        rx_cnt <= 2'h0;               // next byte opens a packet
      else if (rx_cnt != 2'h3)
        rx_cnt <= rx_cnt + 2'h1;      // saturates so long packets never wrap
    end
  end

  // local-time observe flag
  always @(posedge clk_sys)
  begin
    if (sys_rst)
      local_en <= `TFIC_LOCAL_RST;
    else if (pkt_end && (pkt_code == `TFIC_CMD_SET_LOCAL) && flag_ok)
      local_en <= pkt_flag[0];
  end

  // year auto increment flag
  always @(posedge clk_sys)
  begin
    if (sys_rst)
      year_auto_en <= `TFIC_YEAR_RST;
    else if (pkt_end && (pkt_code == `TFIC_CMD_SET_YEAR) && flag_ok)
      year_auto_en <= pkt_flag[0];
  end

  // year store request: raised at the year start, held until acknowledged;
  // a new year start in the ack cycle wins so the event is not lost
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      nv_wr_req <= 1'b0;
      nv_year   <= 16'h0000;
    end
    else if (year_start && year_auto_en)
    begin
      nv_wr_req <= 1'b1;
      nv_year   <= year_value;
    end
    else if (nv_wr_ack)
    begin
      nv_wr_req <= 1'b0;
    end
  end

  // variant strap: two flip-flops, then one capture after reset release
  always @(posedge clk_sys)
  begin
    var_meta <= variant_pin;
    var_sync <= var_meta;
  end

  // identity never moves after capture, whatever packets arrive
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      var_cap  <= 1'b0;
      var_done <= 1'b0;
    end
    else if (!var_done)
    begin
      var_cap  <= var_sync;
      var_done <= 1'b1;
    end
  end

  // next-state logic
  always @*
  begin
    next_state = state;
    case (state)
      S_RX:
      begin
        if (pkt_end && is_query)
          next_state = S_BUILD;       // build the query reply
        else if (pkt_end && (pkt_code == `TFIC_CMD_REQ_DATA) && rpl_ok)
          next_state = S_LOAD;
      end
      S_BUILD:
        if (bld_idx == rpl_len - 4'h1)
          next_state = S_RX;          // reply complete
      S_LOAD:
        next_state = S_SEND;          // buffer data now valid
      S_SEND:
      begin
        if (rsp_ready && (rd_idx == rpl_len - 4'h1))
          next_state = S_RX;          // reply fully taken
        else if (rsp_ready)
          next_state = S_LOAD;        // fetch next byte
      end
      default:
        next_state = S_RX;
    endcase
  end

  // state register
  always @(posedge clk_sys)
  begin
    if (sys_rst)
      state <= S_RX;
    else
      state <= next_state;
  end

  // reply bookkeeping: code, length, build and read indexes
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rpl_code <= 8'h00;
      rpl_len  <= 4'h0;
      rpl_ok   <= 1'b0;
      bld_idx  <= 4'h0;
      rd_idx   <= 4'h0;
    end
    else
    begin
      case (state)
        S_RX:
        begin
          if (pkt_end && is_query)
          begin
            rpl_code <= pkt_code;     // new query replaces the old reply
            rpl_len  <= reply_len(pkt_code);
            rpl_ok   <= 1'b0;
            bld_idx  <= 4'h0;
          end
          rd_idx <= 4'h0;             // reads always start at byte 0
        end
        S_BUILD:
        begin
          if (bld_idx == rpl_len - 4'h1)
          begin
            rpl_ok <= 1'b1;           // reply may now be fetched
          end
          bld_idx <= bld_idx + 4'h1;
        end
        S_SEND:
        begin
          if (rsp_ready)
          begin
            rd_idx <= rd_idx + 4'h1;
          end
        end
        default:
        begin
          rd_idx <= rd_idx;
        end
      endcase
    end
  end

  // buffer write side
  assign bld_wr   = (state == S_BUILD);
  assign bld_byte = reply_byte(rpl_code, bld_idx, local_en, var_cap);
  assign rd_addr  = rd_idx;

  // reply buffer
  tfic_reply_mem #(
    .AW    (`TFIC_BUF_AW),
    .DEPTH (`TFIC_BUF_DEPTH),
    .DW    (8)
  ) u_mem (
    .clk_sys (clk_sys),
    .wr_en   (bld_wr),
    .wr_addr (bld_idx),
    .wr_data (bld_byte),
    .rd_addr (rd_addr),
    .rd_data (rsp_data)
  );

  // reply stream toward the host
  assign rsp_valid = (state == S_SEND);
  assign rsp_last  = (state == S_SEND) && (rd_idx == rpl_len - 4'h1);

  // local time applied to the reported time
  tfic_time_adj #(
    .TW (TW)
  ) u_adj (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .local_en  (local_en),
    .time_in   (time_in),
    .offset_in (local_offset),
    .time_out  (time_out)
  );

endmodule

// ---- tb/tfic_chk.sv ----
/*
  port checker for tfic_top: flag packets, local time adjust, year store
  handshake and reply hold.
  assumes it is bound to tfic_top and shares its clk_sys domain.
*/
`timescale 1ns/1ps
module tfic_chk #(
  parameter TW = 32                      // time word width
) (
  input wire          clk_sys,           // system clock
  input wire          sys_rst,           // synchronous reset
  input wire          cmd_valid,         // packet byte offered
  input wire [7:0]    cmd_data,          // packet byte
  input wire          cmd_last,          // last packet byte
  input wire          cmd_ready,         // packet byte accepted
  input wire          rsp_valid,         // reply byte offered
  input wire [7:0]    rsp_data,          // reply byte
  input wire          rsp_last,          // last reply byte
  input wire          rsp_ready,         // reply byte taken
  input wire [TW-1:0] time_in,           // reference time
  input wire [TW-1:0] local_offset,      // local offset
  input wire [TW-1:0] time_out,          // reported time
  input wire          local_en,          // local-time flag
  input wire          year_auto_en,      // year store flag
  input wire          year_start,        // year start pulse
  input wire [15:0]   year_value,        // current year
  input wire          nv_wr_req,         // year store request
  input wire [15:0]   nv_year,           // year to store
  input wire          nv_wr_ack          // store accepted
);
  reg  [7:0] code_q;                     // first byte of the open packet
  reg  [1:0] cnt;                        // bytes taken in the open packet
  wire       take;                       // byte accepted this cycle
  wire       flag_end;                   // second byte closes the packet
  assign take     = cmd_valid && cmd_ready;
  assign flag_end = take && cmd_last && cnt == 2'h1;
  // follow the byte position inside a packet
  always @(posedge clk_sys)
  begin
    if (sys_rst)
      cnt <= 2'h0;
    else if (take)
      cnt <= cmd_last ? 2'h0 : ((cnt == 2'h3) ? cnt : cnt + 2'h1);
    if (take && cnt == 2'h0)
      code_q <= cmd_data;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  flag_reset_a: assert property (disable iff (1'b0) sys_rst |=> local_en && year_auto_en)
    else $error("flags not enabled after reset");
  local_set_a: assert property (flag_end && code_q == 8'h40 && cmd_data < 8'h02
    |=> {7'h00, local_en} == $past(cmd_data)) else $error("local flag not taken");
  year_set_a: assert property (flag_end && code_q == 8'h42 && cmd_data < 8'h02
    |=> {7'h00, year_auto_en} == $past(cmd_data)) else $error("year flag not taken");
  bad_flag_a: assert property (flag_end && code_q == 8'h40 && cmd_data > 8'h01
    |=> $stable(local_en)) else $error("bad flag byte changed flag");
  time_adj_a: assert property (1'b1 |=> time_out == ($past(local_en) ?
    $past(time_in) + $past(local_offset) : $past(time_in))) else $error("time adjust wrong");
  year_store_a: assert property (year_start && year_auto_en
    |=> nv_wr_req && nv_year == $past(year_value)) else $error("year not stored");
  year_off_a: assert property (year_start && !year_auto_en && !nv_wr_req |=> !nv_wr_req)
    else $error("year stored while disabled");
  year_ack_a: assert property (nv_wr_req && !year_start |=> nv_wr_req == !$past(nv_wr_ack))
    else $error("store request not held to ack");
  rsp_hold_a: assert property (rsp_valid && !rsp_ready
    |=> rsp_valid && $stable(rsp_data) && $stable(rsp_last)) else $error("reply byte dropped");
  cover property (flag_end && code_q == 8'h40 && cmd_data == 8'h00);
  cover property (nv_wr_req && nv_wr_ack);
  cover property (rsp_valid && rsp_ready && rsp_last);
endmodule

// ---- tb/tfic_host_mdl.sv ----
/*
  far-side model: host reply sink with optional stalling, and the
  non-volatile store answering year writes after a short delay.
  assumes the clk_sys domain of tfic_top.
*/
`timescale 1ns/1ps
module tfic_host_mdl (
  input  wire clk_sys,                   // system clock
  input  wire sys_rst,                   // synchronous reset
  input  wire slow,                      // stall every other cycle
  input  wire nv_wr_req,                 // year store request
  output reg  rsp_ready,                 // reply byte taken
  output reg  nv_wr_ack                  // store accepted
);
  reg [1:0] wait_cnt;                    // cycles the store request waited
  // sink and store responder
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rsp_ready <= 1'b0;
      nv_wr_ack <= 1'b0;
      wait_cnt  <= 2'h0;
    end
    else
    begin
      rsp_ready <= slow ? !rsp_ready : 1'b1;
      nv_wr_ack <= nv_wr_req && wait_cnt == 2'h2 && !nv_wr_ack;
      wait_cnt  <= (nv_wr_req && !nv_wr_ack) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule

// ---- tb/tb.sv ----
/*
  testbench for tfic_top: identification rows, flags, status, time adjust
  and year store.
  assumes tfic_chk and tfic_host_mdl are compiled before it.
*/
`timescale 1ns/1ps
module tb;
  localparam [47:0] PART = 48'h41_42_43_44_45_46;       // arbitrary value
  localparam [39:0] REV  = 40'h31_32_33_34_35;          // arbitrary value
  localparam [15:0] ASSY = 16'h1234;                    // arbitrary value
  localparam [15:0] FAB  = 16'hABCD;                    // arbitrary value
  localparam [63:0] MDL  = 64'h4D_4F_44_45_4C_58_59_5A; // arbitrary value
  localparam [7:0]  CH_G = 8'h39;                       // arbitrary value
  localparam [7:0]  CH_T = 8'h33;                       // arbitrary value
  localparam [31:0] SER  = 32'hDEAD_BEEF;               // arbitrary value
  reg         clk_sys, sys_rst, cmd_valid, cmd_last, variant_pin, year_start, slow;
  reg  [7:0]  cmd_data;
  reg  [31:0] time_in, local_offset;
  reg  [15:0] year_value;
  wire        cmd_ready, rsp_valid, rsp_last, rsp_ready, local_en, year_auto_en;
  wire        nv_wr_req, nv_wr_ack;
  wire [7:0]  rsp_data;
  wire [31:0] time_out;
  wire [15:0] nv_year;
  integer     fail_count, comparisons, n, lastn, i, j, k;
  reg  [7:0]  got [0:15];
  reg  [7:0]  r_code [0:4];
  reg  [3:0]  r_len [0:4];
  reg  [87:0] r_exp [0:4];
  tfic_top #(.PART_ID(PART), .FW_REV(REV), .ASSY_NUM(ASSY), .FAB_NUM(FAB), .MODEL(MDL),
    .CH_TCODE(CH_T), .CH_GPS(CH_G), .SERIAL(SER)) u_tfic_top (.clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_last(cmd_last), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_ready(rsp_ready),
    .variant_pin(variant_pin), .time_in(time_in), .local_offset(local_offset),
    .time_out(time_out), .local_en(local_en), .year_auto_en(year_auto_en),
    .year_start(year_start), .year_value(year_value), .nv_wr_req(nv_wr_req),
    .nv_year(nv_year), .nv_wr_ack(nv_wr_ack));
  tfic_host_mdl u_tfic_host_mdl (.clk_sys(clk_sys), .sys_rst(sys_rst), .slow(slow),
    .nv_wr_req(nv_wr_req), .rsp_ready(rsp_ready), .nv_wr_ack(nv_wr_ack));
  // collect reply bytes at each handshake
  always @(posedge clk_sys)
    if (rsp_valid === 1'b1 && rsp_ready === 1'b1)
    begin
      got[n] = rsp_data;
      if (rsp_last === 1'b1)
        lastn = n;
      n = n + 1;
    end
  task check(input [31:0] seen, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      fail_count = fail_count + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  // offer one byte and hold it until taken
  task put(input [7:0] d, input l);
  begin
    cmd_valid <= 1'b1;
    cmd_data  <= d;
    cmd_last  <= l;
    @(posedge clk_sys);
    while (cmd_ready !== 1'b1)
      @(posedge clk_sys);
  end
  endtask
  task pkt(input [7:0] c, input [7:0] f, input two);
  begin
    put(c, !two);
    if (two)
      put(f, 1'b1);
    cmd_valid <= 1'b0;
    @(posedge clk_sys);
  end
  endtask
  // request the buffered reply and compare it byte by byte
  task fetch(input [7:0] c, input [3:0] len, input [87:0] exp);
  begin
    n = 0;
    lastn = 0;
    pkt(8'h19, 8'h00, 1'b0);
    for (i = 0; i < 200 && n < len; i = i + 1)
      @(posedge clk_sys);
    check(n, len);
    check(got[0], c);
    check(lastn, len - 1);
    for (k = 1; k < len; k = k + 1)
      check(got[k], exp[95 - 8 * k -: 8]);
  end
  endtask
  task query(input [7:0] c, input [3:0] len, input [87:0] exp);
  begin
    pkt(c, 8'h00, 1'b0);
    fetch(c, len, exp);
  end
  endtask
  task end_of_test;
  begin
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // watchdog, well past the expected run of a few hundred cycles
  initial
  begin
    #200000;
    fail_count = fail_count + 1;
    end_of_test;
  end
  initial
  begin
    fail_count = 0;
    comparisons = 0;
    n = 0;
    lastn = 0;
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_data = 8'h00;
    cmd_last = 1'b0;
    variant_pin = 1'b1;
    year_start = 1'b0;
    slow = 1'b0;
    year_value = 16'h07D0;
    time_in = 32'h0000_1000;
    local_offset = 32'hFFFF_FFF0;
    r_code[0] = 8'h4F; r_len[0] = 4'hC; r_exp[0] = {PART, REV};
    r_code[1] = 8'hF4; r_len[1] = 4'h3; r_exp[1] = {ASSY, 72'h0};
    r_code[2] = 8'hF5; r_len[2] = 4'h3; r_exp[2] = {FAB, 72'h0};
    r_code[3] = 8'hF6; r_len[3] = 4'h9; r_exp[3] = {MDL[63:32], CH_G, MDL[23:0], 24'h0};
    r_code[4] = 8'hF7; r_len[4] = 4'h5; r_exp[4] = {SER, 56'h0};
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(local_en, 1'b1);
    check(year_auto_en, 1'b1);
    check(time_out, time_in + local_offset);
    $display("reset test done");
    for (j = 0; j < 5; j = j + 1)
      query(r_code[j], r_len[j], r_exp[j]);
    $display("identification rows done");
    pkt(8'h40, 8'h00, 1'b1);
    check(local_en, 1'b0);
    query(8'h41, 4'h2, 88'h0);
    check(time_out, time_in);
    pkt(8'h40, 8'h05, 1'b1);
    check(local_en, 1'b0);
    pkt(8'h40, 8'h01, 1'b1);
    query(8'h41, 4'h2, {8'h08, 80'h0});
    check(time_out, time_in + local_offset);
    $display("local flag test done");
    slow <= 1'b1;
    pkt(8'hF4, 8'h55, 1'b1);
    query(8'hF4, 4'h3, {ASSY, 72'h0});
    fetch(8'hF4, 4'h3, {ASSY, 72'h0});
    slow <= 1'b0;
    $display("request only test done");
    pkt(8'h42, 8'h00, 1'b1);
    check(year_auto_en, 1'b0);
    year_start <= 1'b1;
    @(posedge clk_sys);
    year_start <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(nv_wr_req, 1'b0);
    pkt(8'h42, 8'h01, 1'b1);
    year_value <= 16'h07D1;
    year_start <= 1'b1;
    @(posedge clk_sys);
    year_start <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(nv_wr_req, 1'b1);
    check(nv_year, 16'h07D1);
    repeat (8) @(posedge clk_sys);
    check(nv_wr_req, 1'b0);
    $display("year store test done");
    // mid-run reset with the strap low: flags return, time-code variant captured
    pkt(8'h40, 8'h00, 1'b1);
    variant_pin <= 1'b0;
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(local_en, 1'b1);
    check(year_auto_en, 1'b1);
    query(8'hF6, 4'h9, {MDL[63:32], CH_T, MDL[23:0], 24'h0});
    $display("second reset test done");
    end_of_test;
  end
endmodule
bind tfic_top tfic_chk #(.TW(TW)) u_tfic_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_last(cmd_last), .cmd_ready(cmd_ready),
  .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_ready(rsp_ready),
  .time_in(time_in), .local_offset(local_offset), .time_out(time_out),
  .local_en(local_en), .year_auto_en(year_auto_en), .year_start(year_start),
  .year_value(year_value), .nv_wr_req(nv_wr_req), .nv_year(nv_year), .nv_wr_ack(nv_wr_ack));
